// ### pkg/mci_map.svh
// Register offsets, field positions, reset values and limits of the block
`ifndef MCI_MAP_SVH
`define MCI_MAP_SVH
`define MCI_ADDR_W 4
`define MCI_OFF_INIT 4'h0
`define MCI_OFF_STATUS 4'h1
`define MCI_OFF_RES16 4'h2
`define MCI_OFF_EVT 4'h3
`define MCI_OFF_MASK 4'h4
`define MCI_OFF_FLAGS 4'h5
`define MCI_INIT_RST 16'h0040
`define MCI_INIT_MASK 16'h00D0
`define MCI_RES16_RST 16'h0000
`define MCI_RES16_MAX 16'h7FFF
`define MCI_BIT_OTPW 7
`define MCI_BIT_PFEN 6
`define MCI_BIT_SWEN 4
`define MCI_EVT_W 4
`define MCI_EVT_PF 0
`define MCI_EVT_OTP_DONE 1
`define MCI_EVT_OTP_HELD 2
`define MCI_EVT_TEST_DROP 3
`endif

// ### pkg/mci_pkg.sv
// Types shared by the manufacturing configuration block
package mci_pkg;
	typedef enum logic [1:0] {
		MCI_OTP_NONE = 2'b00,
		MCI_OTP_DIAG = 2'b01,
		MCI_OTP_MAKER = 2'b10
	} mci_otp_e;
endpackage : mci_pkg

// ### src/mci_top.sv
// Manufacturing control word, live status, switch gating, cell 16 correction
`timescale 1ns/1ps
`include "mci_map.svh"
// Operation
// - Cell 16 voltage corrected by current times resistance 0..32767, default zero.
// - Init word (default 0x0040) copied to live status on reset, lock, config entry.
// - Bit 7 clear blocks runtime one-time memory programming.
// - Memory writes only while stack voltage and temperature are within limits.
// - Config update mode still allows maker data programming with bit 7 clear.
// - If allowed, permanent failure or blown fuse records diagnostics to memory.
// - Host request in unrestricted access programs maker data block if allowed.
// - Bit 6 enables failure checks, default one; zero never trips failure.
// - Bit 4 one: normal control, switch-test subcommands discarded.
// - Protection may force switches off, or one on for body diode.
module mci_top (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic irq,
	input wire logic lock_command,
	input wire logic enter_config_update_command,
	input wire logic config_update_mode,
	input wire logic unrestricted_access_state,
	input wire logic maker_data_request,
	input wire logic failure_detect,
	input wire logic fuse_blown,
	input wire logic stack_v_ok,
	input wire logic temp_ok,
	input wire logic otp_busy,
	output logic otp_write_start,
	output logic [1:0] otp_write_kind,
	output logic permanent_failure,
	input wire logic [1:0] normal_switch_req,
	input wire logic test_cmd_valid,
	input wire logic [1:0] test_cmd_switch,
	input wire logic [1:0] prot_force_off,
	input wire logic [1:0] prot_force_on,
	output logic [1:0] switch_on,
	input wire logic cell_valid,
	input wire logic signed [15:0] cell16_raw_mv,
	input wire logic signed [15:0] current_ma,
	output logic signed [15:0] cell16_corr_mv,
	output logic cell16_corr_valid
);
	// ==========================================================
	// Registers
	logic [15:0] init_q;
	logic [15:0] status_q;
	logic [15:0] res16_q;
	logic [`MCI_EVT_W-1:0] evt_q;
	logic [`MCI_EVT_W-1:0] mask_q;
	logic [1:0] test_sw_q;
	logic pf_q;
	logic pend_diag_q;
	logic pend_maker_q;
	logic [1:0] kind_q;
	logic start_q;
	logic [15:0] rdata_q;
	logic signed [15:0] corr_q;
	logic corr_v_q;
	logic [1:0] sync1_q;
	logic [1:0] sync2_q;

	// ==========================================================
	// Decode
	wire wr_init = reg_wr && reg_addr == `MCI_OFF_INIT;
	wire wr_res = reg_wr && reg_addr == `MCI_OFF_RES16;
	wire wr_evt = reg_wr && reg_addr == `MCI_OFF_EVT;
	wire wr_mask = reg_wr && reg_addr == `MCI_OFF_MASK;
	wire reload = lock_command || enter_config_update_command;
	wire otp_allow = status_q[`MCI_BIT_OTPW];
	wire pf_check = status_q[`MCI_BIT_PFEN];
	wire normal_ctl = status_q[`MCI_BIT_SWEN];
	// Stack and temperature pins are asynchronous, so they are synchronised
	wire limits_ok = sync2_q[0] && sync2_q[1];
	wire prog_ok = (otp_allow || config_update_mode) && limits_ok;
	wire pf_trip = failure_detect && pf_check && !pf_q;
	wire diag_req = (pf_trip || fuse_blown) && otp_allow;
	wire maker_req = maker_data_request && unrestricted_access_state
		&& (otp_allow || config_update_mode);
	wire diag_go = pend_diag_q && prog_ok && !otp_busy && !start_q;
	wire maker_go = pend_maker_q && prog_ok && !otp_busy && !start_q
		&& !pend_diag_q;
	wire held = (pend_diag_q || pend_maker_q) && !limits_ok;
	wire test_drop = test_cmd_valid && normal_ctl;
	wire [`MCI_EVT_W-1:0] evt_set;
	assign evt_set[`MCI_EVT_PF] = pf_trip;
	assign evt_set[`MCI_EVT_OTP_DONE] = diag_go || maker_go;
	assign evt_set[`MCI_EVT_OTP_HELD] = held;
	assign evt_set[`MCI_EVT_TEST_DROP] = test_drop;
	// Set wins over write-one-to-clear
	wire [`MCI_EVT_W-1:0] evt_d = (evt_q & ~(wr_evt ?
		reg_wdata[`MCI_EVT_W-1:0] : {`MCI_EVT_W{1'b0}})) | evt_set;
	// Reserved bits dropped on write so they can never steer anything
	wire [15:0] init_d = reg_wdata & `MCI_INIT_MASK;
	wire [15:0] res_d = reg_wdata & `MCI_RES16_MAX;
	wire [1:0] sw_base = normal_ctl ? normal_switch_req : test_sw_q;
	// Protection has last say over both control paths
	wire [1:0] sw_d = (sw_base & ~prot_force_off) | prot_force_on;
	// 16x15 product fits 32 bits; result is clamped to 16 bits
	wire signed [31:0] drop_uv = current_ma * $signed({1'b0, res16_q[14:0]});
	wire signed [31:0] corr_full = 32'(cell16_raw_mv) - (drop_uv / 1000);
	wire signed [15:0] corr_d = corr_full > 32'sh7FFF ? 16'sh7FFF :
		corr_full < -32'sh8000 ? -16'sh8000 : corr_full[15:0];
	wire [15:0] rd_mux =
		reg_addr == `MCI_OFF_INIT ? init_q :
		reg_addr == `MCI_OFF_STATUS ? status_q :
		reg_addr == `MCI_OFF_RES16 ? res16_q :
		reg_addr == `MCI_OFF_EVT ? {12'h000, evt_q} :
		reg_addr == `MCI_OFF_MASK ? {12'h000, mask_q} :
		reg_addr == `MCI_OFF_FLAGS ? {13'h0000, pf_q, switch_on} :
		16'h0000;

	// ==========================================================
	// Stored initial word
	// A write here reaches the live status only at the next reload
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			init_q <= `MCI_INIT_RST;
		end else if (wr_init) begin
			init_q <= init_d;
		end
	end

	// ==========================================================
	// Live status
	// Software cannot write it, so behaviour changes only on a reload
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			status_q <= `MCI_INIT_RST;
		end else if (reload) begin
			status_q <= init_q;
		end
	end

	// ==========================================================
	// Cell 16 interconnect resistance
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			res16_q <= `MCI_RES16_RST;
		end else if (wr_res) begin
			res16_q <= res_d;
		end
	end

	// ==========================================================
	// Event mask and sticky events
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mask_q <= {`MCI_EVT_W{1'b0}};
		end else if (wr_mask) begin
			mask_q <= reg_wdata[`MCI_EVT_W-1:0];
		end
	end

	// A clear in the cycle of a new event loses, so no event is missed
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			evt_q <= {`MCI_EVT_W{1'b0}};
		end else begin
			evt_q <= evt_d;
		end
	end

	// ==========================================================
	// Limit synchroniser
	// Only the second stage feeds logic, the first may be metastable
	// Costs two cycles of lag on a limit change, harmless for writes
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sync1_q <= 2'b00;
			sync2_q <= 2'b00;
		end else begin
			sync1_q <= {temp_ok, stack_v_ok};
			sync2_q <= sync1_q;
		end
	end

	// ==========================================================
	// Failure latch
	// Clears only on reset, as a real failure would persist
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pf_q <= 1'b0;
		end else if (pf_trip) begin
			pf_q <= 1'b1;
		end
	end

	// ==========================================================
	// Memory write requests
	// A request waits here while limits or the programmer hold it off
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pend_diag_q <= 1'b0;
		end else begin
			pend_diag_q <= (pend_diag_q && !diag_go) || diag_req;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pend_maker_q <= 1'b0;
		end else begin
			pend_maker_q <= (pend_maker_q && !maker_go) || maker_req;
		end
	end

	// ==========================================================
	// Memory write start
	// One start per write; the busy flag of the programmer spaces them
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			start_q <= 1'b0;
		end else begin
			start_q <= diag_go || maker_go;
		end
	end

	// Diagnostic record wins, a failure state matters more than data
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			kind_q <= mci_pkg::MCI_OTP_NONE;
		end else if (diag_go) begin
			kind_q <= mci_pkg::MCI_OTP_DIAG;
		end else if (maker_go) begin
			kind_q <= mci_pkg::MCI_OTP_MAKER;
		end
	end

	// ==========================================================
	// Switch-test latch
	// Cleared under normal control so a stale test state cannot return
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			test_sw_q <= 2'b00;
		end else if (test_cmd_valid && !normal_ctl) begin
			test_sw_q <= test_cmd_switch;
		end else if (normal_ctl) begin
			test_sw_q <= 2'b00;
		end
	end

	// ==========================================================
	// Switch outputs
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			switch_on <= 2'b00;
		end else begin
			switch_on <= sw_d;
		end
	end

	// ==========================================================
	// Corrected cell voltage
	// Result holds between samples; the valid pulse marks a new one
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			corr_q <= 16'sh0000;
		end else if (cell_valid) begin
			corr_q <= corr_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			corr_v_q <= 1'b0;
		end else begin
			corr_v_q <= cell_valid;
		end
	end

	// ==========================================================
	// Read port
	// Data is held until the next read strobe
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata_q <= 16'h0000;
		end else if (reg_rd) begin
			rdata_q <= rd_mux;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata = rdata_q;
	assign irq = |(evt_q & mask_q);
	assign otp_write_start = start_q;
	assign otp_write_kind = kind_q;
	assign permanent_failure = pf_q;
	assign cell16_corr_mv = corr_q;
	assign cell16_corr_valid = corr_v_q;
endmodule : mci_top

// ### tb/mci_otp_model.sv
// Memory programmer: busy for a few cycles after every write start
`timescale 1ns/1ps
module mci_otp_model (
	input wire logic sys_clk,
	input wire logic otp_write_start,
	output logic otp_busy
);
	// Busy spans several cycles so back-to-back starts must wait
	int n = 0;
	assign otp_busy = (n != 0);
	always_ff @(posedge sys_clk) begin
		n <= otp_write_start ? 3 : (n != 0 ? n - 1 : 0);
	end
endmodule : mci_otp_model

// ### tb/mci_top_props.sv
// Port-level assertions for the manufacturing configuration block
`timescale 1ns/1ps
module mci_top_props (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic otp_busy,
	input wire logic otp_write_start,
	input wire logic [1:0] otp_write_kind,
	input wire logic failure_detect,
	input wire logic permanent_failure,
	input wire logic [1:0] prot_force_off,
	input wire logic [1:0] prot_force_on,
	input wire logic [1:0] switch_on,
	input wire logic cell_valid,
	input wire logic cell16_corr_valid
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	// ==========
	// Properties
	sequence s_trip;
		$rose(permanent_failure);
	endsequence
	AST_CORR_LAT: assert property (cell_valid |=> cell16_corr_valid)
		else $error("correction late");
	AST_CORR_ONE: assert property (!cell_valid |=> !cell16_corr_valid)
		else $error("stray correction");
	AST_FORCE_ON: assert property (prot_force_on != 2'h0 |=>
		(switch_on & $past(prot_force_on)) == $past(prot_force_on))
		else $error("force on lost");
	AST_FORCE_OFF: assert property (prot_force_off != 2'h0 |=>
		(switch_on & $past(prot_force_off & ~prot_force_on)) == 2'h0)
		else $error("force off lost");
	AST_OTP_IDLE: assert property (otp_write_start |-> $past(!otp_busy))
		else $error("write while busy");
	AST_OTP_KIND: assert property (otp_write_start |->
		otp_write_kind inside {mci_pkg::MCI_OTP_DIAG, mci_pkg::MCI_OTP_MAKER})
		else $error("bad write kind");
	AST_TRIP_CAUSE: assert property (s_trip |-> $past(failure_detect))
		else $error("trip without cause");
	AST_TRIP_HOLD: assert property (permanent_failure |=> permanent_failure)
		else $error("trip not sticky");
endmodule : mci_top_props
bind mci_top mci_top_props i_mci_top_props (.*);

// ### tb/mci_top_tb.sv
// Self-checking bench for the manufacturing configuration block
`timescale 1ns/1ps
`include "mci_map.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
$display("unexpected %0t got %h exp %h", $time, a, b); end end
module mci_top_tb;
	logic sys_clk = 0, srst = 1, wr = 0, rd = 0, lk = 0, cu = 0, cm = 0;
	logic mr = 0, fd = 0, sv = 1, tp = 1, busy, st, pf, irq, tv = 0, cv = 0;
	logic [3:0] a = 0;
	logic [15:0] wd = 0, rdat, raw = 0, cur = 0, corr;
	logic [1:0] kind, nr = 0, ts = 0, off = 0, on = 0, sw;
	logic cvv;
	int err_count = 0, compares = 0;
	mci_otp_model i_mci_otp_model (.sys_clk(sys_clk), .otp_write_start(st),
		.otp_busy(busy));
	mci_top i_mci_top (.sys_clk(sys_clk), .srst(srst), .reg_addr(a),
		.reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .irq(irq),
		.lock_command(lk), .enter_config_update_command(cu),
		.config_update_mode(cm), .unrestricted_access_state(1'b1),
		.maker_data_request(mr), .failure_detect(fd), .fuse_blown(1'b0),
		.stack_v_ok(sv), .temp_ok(tp), .otp_busy(busy), .otp_write_start(st),
		.otp_write_kind(kind), .permanent_failure(pf), .normal_switch_req(nr),
		.test_cmd_valid(tv), .test_cmd_switch(ts), .prot_force_off(off),
		.prot_force_on(on), .switch_on(sw), .cell_valid(cv),
		.cell16_raw_mv(raw), .current_ma(cur), .cell16_corr_mv(corr),
		.cell16_corr_valid(cvv));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	// ==========
	// Bus cycles
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task w(input logic [3:0] ad, input logic [15:0] d);
		@(posedge sys_clk) {wr, a, wd} <= {1'b1, ad, d};
		@(posedge sys_clk) wr <= 1'b0;
	endtask : w
	task r(input logic [3:0] ad, input logic [15:0] e);
		@(posedge sys_clk) {rd, a} <= {1'b1, ad};
		@(posedge sys_clk) rd <= 1'b0;
		#1;
		`CHK(rdat, e)
	endtask : r
	task lock();
		@(posedge sys_clk) lk <= 1'b1;
		@(posedge sys_clk) lk <= 1'b0;
		cyc(2);
	endtask : lock
	task ws(input logic [1:0] k, input logic e);
		logic s;
		s = 0;
		repeat (8) begin
			cyc(1);
			if (st === 1'b1) begin
				s = 1;
				`CHK(kind, k)
			end
		end
		`CHK(s, e)
	endtask : ws
	// ==========
	// Scenarios
	task t_reg();
		r(`MCI_OFF_INIT, 16'h0040);
		r(`MCI_OFF_STATUS, 16'h0040);
		r(`MCI_OFF_RES16, 16'h0000);
		w(`MCI_OFF_INIT, 16'hFFFF);
		r(`MCI_OFF_INIT, 16'h00D0);
		r(4'hF, 16'h0000);
		lock();
		r(`MCI_OFF_STATUS, 16'h00D0);
	endtask : t_reg
	task t_pf_otp();
		w(`MCI_OFF_INIT, 16'h0090);
		@(posedge sys_clk) cu <= 1'b1;
		@(posedge sys_clk) {cu, fd} <= 2'b01;
		cyc(4);
		`CHK(pf, 1'b0)
		fd <= 1'b0;
		w(`MCI_OFF_INIT, 16'h00C0);
		lock();
		fd <= 1'b1;
		cyc(1);
		`CHK(pf, 1'b1)
		ws(mci_pkg::MCI_OTP_DIAG, 1'b1);
		{fd, sv, tp} <= 3'b010;
		@(posedge sys_clk) mr <= 1'b1;
		@(posedge sys_clk) mr <= 1'b0;
		ws(mci_pkg::MCI_OTP_MAKER, 1'b0);
		tp <= 1'b1;
		ws(mci_pkg::MCI_OTP_MAKER, 1'b1);
		w(`MCI_OFF_INIT, 16'h0050);
		lock();
		@(posedge sys_clk) mr <= 1'b1;
		@(posedge sys_clk) mr <= 1'b0;
		ws(mci_pkg::MCI_OTP_MAKER, 1'b0);
		cm <= 1'b1;
		@(posedge sys_clk) mr <= 1'b1;
		@(posedge sys_clk) mr <= 1'b0;
		ws(mci_pkg::MCI_OTP_MAKER, 1'b1);
		cm <= 1'b0;
	endtask : t_pf_otp
	task t_sw();
		w(`MCI_OFF_EVT, 16'h000F);
		w(`MCI_OFF_MASK, 16'h0008);
		{nr, ts} <= 4'hE;
		cyc(2);
		`CHK(sw, 2'h3)
		@(posedge sys_clk) tv <= 1'b1;
		@(posedge sys_clk) tv <= 1'b0;
		cyc(2);
		`CHK({irq, sw}, 3'h7)
		r(`MCI_OFF_EVT, 16'h0008);
		w(`MCI_OFF_EVT, 16'h0008);
		cyc(1);
		`CHK(irq, 1'b0)
		w(`MCI_OFF_INIT, 16'h0040);
		lock();
		`CHK(sw, 2'h0)
		@(posedge sys_clk) tv <= 1'b1;
		@(posedge sys_clk) tv <= 1'b0;
		cyc(2);
		`CHK(sw, 2'h2)
		{off, on} <= 4'h9;
		cyc(2);
		`CHK(sw, 2'h1)
	endtask : t_sw
	task t_cell();
		w(`MCI_OFF_RES16, 16'hFFFF);
		r(`MCI_OFF_RES16, `MCI_RES16_MAX);
		w(`MCI_OFF_RES16, 16'h03E8);
		@(posedge sys_clk) {cv, raw, cur} <= {1'b1, 16'h0BB8, 16'h01F4};
		@(posedge sys_clk) cv <= 1'b0;
		#1;
		`CHK(corr, 16'h09C4)
		`CHK(cvv, 1'b1)
		cyc(1);
		`CHK(cvv, 1'b0)
	endtask : t_cell
	task conclude();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	initial begin
		#100000;
		err_count++;
		conclude();
	end
	initial begin
		cyc(12);
		srst <= 1'b0;
		t_reg();
		t_pf_otp();
		t_sw();
		t_cell();
		conclude();
	end
endmodule : mci_top_tb
